// ### include/hppc_pkg.sv
/*
  Package for the hub downstream port power control: register indices,
  field positions, reset values and bus widths.
  Assumes an APB master with 32-bit data and byte addressing.
*/
package hppc_pkg;
  localparam int HPPC_ADDR_W = 12;
  localparam int HPPC_DATA_W = 32;
  // Printed offsets are not word aligned, so they are indices; byte address is index * 4
  localparam logic [HPPC_ADDR_W-1:0] HPPC_PPC_IDX = 12'h09A;
  localparam logic [HPPC_ADDR_W-1:0] HPPC_HSR_IDX = 12'h09B;
  localparam logic [HPPC_ADDR_W-1:0] HPPC_PPC_ADDR = HPPC_PPC_IDX << 2;
  localparam logic [HPPC_ADDR_W-1:0] HPPC_HSR_ADDR = HPPC_HSR_IDX << 2;
  // Port power control fields
  localparam int HPPC_EXT_LO = 2;
  localparam int HPPC_EXT_HI = 5;
  localparam int HPPC_INT_BIT = 1;
  localparam logic [3:0] HPPC_EXT_RST = 4'h0;
  // Hub status fields
  localparam int HPPC_OC_LEVEL_BIT = 1;
  localparam int HPPC_OC_CHANGE_BIT = 3;
  localparam int HPPC_EP_EN_BIT = 4;
  localparam int HPPC_OC_DET_EN_BIT = 7;
  localparam logic HPPC_OC_DET_EN_RST = 1'b0;
  localparam logic HPPC_EP_EN_RST = 1'b0;
endpackage

// ### logic/hppc_port_power.sv
/*
  Ganged downstream port power control for an embedded hub, with an APB
  register slave, overcurrent sense and a shared active-low power enable.
  Assumes one 25 MHz clock, a synchronous active-high reset, and a root
  port reset pulse from logic on the same clock.
*/
`timescale 1ns/100ps
module hppc_port_power
  import hppc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [hppc_pkg::HPPC_ADDR_W-1:0] paddr_in,
  input wire logic [hppc_pkg::HPPC_DATA_W-1:0] pwdata_in,
  output logic [hppc_pkg::HPPC_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Hub events
  input wire logic root_reset_in,
  // Board power switch and sensor
  input wire logic overcurrent_in_n,
  output logic port_power_enable_n_out
);
  import hppc_pkg::*;

  logic [3:0] ext_port_power_bits_r;
  logic overcurrent_detect_enable_r;
  logic status_endpoint_enable_r;
  logic overcurrent_change_flag_r;
  logic oc_meta_r;
  logic oc_sync_r;
  logic oc_prev_r;
  logic pwr_en_n_r;
  logic pready_r;
  logic pslverr_r;
  logic [HPPC_DATA_W-1:0] prdata_r;
  logic setup_phase;
  logic wr_access;
  logic oc_active;
  logic oc_changed;
  logic [7:0] ppc_rd;
  logic [7:0] hsr_rd;

  function automatic logic is_mapped(input logic [HPPC_ADDR_W-1:0] a);
    is_mapped = (a == HPPC_PPC_ADDR) || (a == HPPC_HSR_ADDR);
  endfunction

  // Access completes in the first access cycle: pready is raised from the setup cycle
  assign setup_phase = psel_in && !penable_in && !pready_r;
  assign wr_access = psel_in && penable_in && pready_r && pwrite_in;

  // Overcurrent pin, two flops before the register logic; only the enable output reads the raw pin
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      oc_meta_r <= 1'b1;
      oc_sync_r <= 1'b1;
      oc_prev_r <= 1'b1;
    end else begin
      oc_meta_r <= overcurrent_in_n;
      oc_sync_r <= oc_meta_r;
      oc_prev_r <= oc_sync_r;
    end
  end

  assign oc_active = overcurrent_detect_enable_r && !oc_sync_r;
  assign oc_changed = oc_sync_r != oc_prev_r;

  // External port power bits
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || root_reset_in) begin
      ext_port_power_bits_r <= HPPC_EXT_RST;
    end else if (oc_active) begin
      // Held clear for as long as overcurrent lasts so the switch cannot cycle
      ext_port_power_bits_r <= HPPC_EXT_RST;
    end else if (wr_access && paddr_in == HPPC_PPC_ADDR) begin
      ext_port_power_bits_r <= pwdata_in[HPPC_EXT_HI:HPPC_EXT_LO];
    end
  end

  // Hub status control bits
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      overcurrent_detect_enable_r <= HPPC_OC_DET_EN_RST;
      status_endpoint_enable_r <= HPPC_EP_EN_RST;
    end else if (wr_access && paddr_in == HPPC_HSR_ADDR) begin
      overcurrent_detect_enable_r <= pwdata_in[HPPC_OC_DET_EN_BIT];
      status_endpoint_enable_r <= pwdata_in[HPPC_EP_EN_BIT];
    end
  end

  // Sticky change flag, write one to clear; a new change wins over the clear
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      overcurrent_change_flag_r <= 1'b0;
    end else if (oc_changed) begin
      overcurrent_change_flag_r <= 1'b1;
    end else if (wr_access && paddr_in == HPPC_HSR_ADDR && pwdata_in[HPPC_OC_CHANGE_BIT]) begin
      overcurrent_change_flag_r <= 1'b0;
    end
  end

  // Shared enable, registered part
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pwr_en_n_r <= 1'b1;
    end else begin
      pwr_en_n_r <= !((|ext_port_power_bits_r) && status_endpoint_enable_r && !oc_active);
    end
  end

  // The raw pin bypasses the clock here so a short circuit cuts power at once
  assign port_power_enable_n_out = pwr_en_n_r
                                   | (overcurrent_detect_enable_r & ~overcurrent_in_n);

  // Read views; reserved bits read zero and software must write them as zero
  always_comb begin
    ppc_rd = 8'h00;
    ppc_rd[HPPC_EXT_HI:HPPC_EXT_LO] = ext_port_power_bits_r;
    ppc_rd[HPPC_INT_BIT] = 1'b1;
    hsr_rd = 8'h00;
    hsr_rd[HPPC_OC_DET_EN_BIT] = overcurrent_detect_enable_r;
    hsr_rd[HPPC_EP_EN_BIT] = status_endpoint_enable_r;
    hsr_rd[HPPC_OC_CHANGE_BIT] = overcurrent_change_flag_r;
    hsr_rd[HPPC_OC_LEVEL_BIT] = oc_sync_r;
  end

  // APB answer
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready_r <= 1'b1;
      pslverr_r <= !is_mapped(paddr_in);
      if (paddr_in == HPPC_PPC_ADDR && !pwrite_in) begin
        prdata_r <= {24'h00_0000, ppc_rd};
      end else if (paddr_in == HPPC_HSR_ADDR && !pwrite_in) begin
        prdata_r <= {24'h00_0000, hsr_rd};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out = prdata_r;

  // Checks
  sequence oc_seen_s;
    overcurrent_detect_enable_r && !oc_sync_r;
  endsequence

  sequence bits_cleared_s;
    ext_port_power_bits_r == 4'h0;
  endsequence

  oc_clears_bits_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    oc_seen_s |=> bits_cleared_s)
    else $error("Port bits not cleared on overcurrent");

  pin_forces_off_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (overcurrent_detect_enable_r && !overcurrent_in_n) |-> port_power_enable_n_out)
    else $error("Enable active during overcurrent");

  enable_asserts_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((|ext_port_power_bits_r) && status_endpoint_enable_r && !oc_active)
    |=> !pwr_en_n_r)
    else $error("Enable not asserted");

  zero_bits_off_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($past(ext_port_power_bits_r) == 4'h0) |-> port_power_enable_n_out)
    else $error("Enable asserted with no port bits");

  ep_gate_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !$past(status_endpoint_enable_r) |-> port_power_enable_n_out)
    else $error("Enable asserted without status endpoint");

  detect_gate_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (!overcurrent_detect_enable_r && wr_access && paddr_in == HPPC_PPC_ADDR
     && !root_reset_in) |=> ext_port_power_bits_r == $past(pwdata_in[5:2]))
    else $error("Write lost while detection disabled");

  // A clear written in the cycle after the set is legal, so the second cycle allows it
  change_sticky_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (oc_sync_r != oc_prev_r) |=> overcurrent_change_flag_r ##1 (overcurrent_change_flag_r
    || $past(wr_access && paddr_in == HPPC_HSR_ADDR && pwdata_in[HPPC_OC_CHANGE_BIT])))
    else $error("Change flag not sticky");

  root_reset_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    root_reset_in |=> bits_cleared_s ##1 port_power_enable_n_out)
    else $error("Root reset did not power off ports");

  internal_bit_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (pready_r && !pwrite_in && paddr_in == HPPC_PPC_ADDR) |-> prdata_r[1])
    else $error("Internal port bit read zero");

  // Pin edges held two cycles, so the synchroniser has surely passed them
  sequence pin_fall_held_s;
    $fell(overcurrent_in_n) ##1 !overcurrent_in_n;
  endsequence

  sequence pin_rise_held_s;
    $rose(overcurrent_in_n) ##1 overcurrent_in_n;
  endsequence

  // Watches the pin itself so only the second flop reads the first one
  level_report_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    pin_fall_held_s |=> !hsr_rd[HPPC_OC_LEVEL_BIT])
    else $error("Overcurrent level not reported");

  // Level returns to one once the fault has gone
  level_rise_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    pin_rise_held_s |=> hsr_rd[HPPC_OC_LEVEL_BIT])
    else $error("Overcurrent release not reported");

  // A status read carries the level seen in the setup cycle
  hsr_read_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (pready_r && !pwrite_in && paddr_in == HPPC_HSR_ADDR) |-> prdata_r[1] == $past(oc_sync_r))
    else $error("Status read shows wrong level");

  // Zero wait states: the access phase always finds pready high
  ready_after_setup_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    setup_phase |=> pready_r)
    else $error("No ready after setup");

  // A second pulse would complete a transfer the master never asked for
  ready_one_cycle_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    pready_r |=> !pready_r)
    else $error("Ready held too long");

  // Unmapped addresses answer with an error and zero data
  unmapped_error_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (setup_phase && !is_mapped(paddr_in)) |=> pslverr_r)
    else $error("Unmapped access without error");

  unmapped_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (setup_phase && !is_mapped(paddr_in)) |=> prdata_r == 32'h0000_0000)
    else $error("Unmapped read returned data");

  // Reserved positions read zero whatever software wrote there
  reserved_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (pready_r && !pwrite_in && paddr_in == HPPC_PPC_ADDR) |-> (prdata_r[7:6] == 2'h0 && !prdata_r[0]))
    else $error("Reserved bits read nonzero");

  // Writes land as written when nothing refuses them
  ppc_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (wr_access && paddr_in == HPPC_PPC_ADDR && !oc_active && !root_reset_in)
    |=> ext_port_power_bits_r == $past(pwdata_in[HPPC_EXT_HI:HPPC_EXT_LO]))
    else $error("Port power write lost");

  // Bits stay clear when the fault lifts; only a new write powers ports again
  oc_stays_off_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($rose(oc_sync_r) && $past(overcurrent_detect_enable_r)) |-> bits_cleared_s)
    else $error("Port bits survived overcurrent");

  // With detection off the pin has no path to the enable
  detect_off_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !overcurrent_detect_enable_r |-> port_power_enable_n_out == pwr_en_n_r)
    else $error("Disabled pin affects enable");

  detect_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (wr_access && paddr_in == HPPC_HSR_ADDR)
    |=> overcurrent_detect_enable_r == $past(pwdata_in[HPPC_OC_DET_EN_BIT]))
    else $error("Detect enable write lost");

  ep_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (wr_access && paddr_in == HPPC_HSR_ADDR)
    |=> status_endpoint_enable_r == $past(pwdata_in[HPPC_EP_EN_BIT]))
    else $error("Endpoint enable write lost");

  // A clear with no new change must take effect
  flag_clear_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (wr_access && paddr_in == HPPC_HSR_ADDR && pwdata_in[HPPC_OC_CHANGE_BIT] && !oc_changed)
    |=> !overcurrent_change_flag_r)
    else $error("Change flag not cleared");
endmodule // hppc_port_power

// ### verif/hppc_sense_model.sv
/*
  Board side of the port power block: ganged power switch and overcurrent sensor.
  Assumes the bench commands faults through fault_in; the sensor line has a pull-up.
*/
`timescale 1ns/100ps
module hppc_sense_model (
  // Bench command
  input wire logic fault_in,
  // Power switch and sensor
  input wire logic enable_n_in,
  output logic overcurrent_n_out,
  output logic rail_on_out
);
  // Open-drain sensor: the pull-up holds the line high unless a fault pulls it down
  assign overcurrent_n_out = fault_in ? 1'b0 : 1'b1;
  // A faulted rail never carries power, whatever the enable says
  assign rail_on_out = (enable_n_in === 1'b0) && !fault_in;
endmodule // hppc_sense_model

// ### verif/tb.sv
/*
  Self-checking bench for the hub port power block, one task per scenario.
  Assumes the package and the sense model are compiled before this file.
*/
`timescale 1ns/100ps
module tb;
  import hppc_pkg::*;
  localparam logic [11:0] PPC_A = HPPC_PPC_ADDR;
  localparam logic [11:0] HSR_A = HPPC_HSR_ADDR;
  logic clock_in, sys_rst_in, psel, pen, pwr, root_rst, fault, pready, pslverr, oc_n, en_n, err;
  logic rail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total = 0;
  int cmp_count = 0;
  hppc_port_power dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .root_reset_in(root_rst), .overcurrent_in_n(oc_n), .port_power_enable_n_out(en_n));
  hppc_sense_model sense_u (.fault_in(fault), .enable_n_in(en_n), .overcurrent_n_out(oc_n),
    .rail_on_out(rail));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic chk_en(input string n, input logic e);
    chk(n, {31'h0, en_n}, {31'h0, e});
  endtask
  // Waits for pready with no assumed latency; the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic settle_en(input string n, input logic e);
    repeat (2) @(posedge clock_in);
    #1 chk_en(n, e);
  endtask
  task automatic t_reset();
    apb(1'b0, PPC_A, 32'h0);
    chk("ppc_reset", rd, 32'h02);
    chk_en("en_reset", 1'b1);
  endtask
  task automatic t_ports();
    apb(1'b1, HSR_A, 32'h80);
    apb(1'b1, PPC_A, 32'h04);
    settle_en("en_no_ep", 1'b1);
    apb(1'b1, HSR_A, 32'h90);
    for (int p = 2; p <= 5; p++) begin
      apb(1'b1, PPC_A, 32'h1 << p);
      settle_en("en_port", 1'b0);
      chk("rail_on", {31'h0, rail}, 32'h1);
      apb(1'b0, PPC_A, 32'h0);
      chk("ppc_port", rd, (32'h1 << p) | 32'h2);
    end
    apb(1'b1, PPC_A, 32'h0);
    settle_en("en_all_off", 1'b1);
  endtask
  task automatic t_overcurrent();
    apb(1'b1, PPC_A, 32'h3C);
    fault <= 1'b1;
    #1 chk_en("en_oc", 1'b1);
    repeat (4) @(posedge clock_in);
    apb(1'b0, PPC_A, 32'h0);
    chk("ppc_oc", rd, 32'h02);
    apb(1'b0, HSR_A, 32'h0);
    chk("hsr_oc", rd, 32'h98);
    fault <= 1'b0;
    repeat (5) @(posedge clock_in);
    #1 chk_en("en_after_oc", 1'b1);
    apb(1'b1, HSR_A, 32'h98);
    apb(1'b0, HSR_A, 32'h0);
    chk("hsr_clear", rd, 32'h92);
    apb(1'b1, PPC_A, 32'h04);
    settle_en("en_again", 1'b0);
  endtask
  task automatic t_detect_off();
    apb(1'b1, HSR_A, 32'h10);
    fault <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1 chk_en("en_oc_off", 1'b0);
    apb(1'b0, PPC_A, 32'h0);
    chk("ppc_oc_off", rd, 32'h06);
    fault <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic t_root_and_unmapped();
    @(posedge clock_in);
    root_rst <= 1'b1;
    @(posedge clock_in);
    root_rst <= 1'b0;
    settle_en("en_root", 1'b1);
    apb(1'b0, PPC_A, 32'h0);
    chk("ppc_root", rd, 32'h02);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
  endtask
  initial begin
    {psel, pen, pwr, root_rst, fault} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_ports();
    t_overcurrent();
    t_detect_off();
    t_root_and_unmapped();
    stop_test();
  end
  // The scenarios take well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule // tb
